// >>> bench/esa_regs_tb_top.sv
`timescale 1ns/1ps
module esa_regs_tb_top;
  logic        clock, rstn, hsel, hwrite, hready, hreadyout, hresp, cap;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, lsf;
  logic [2:0]  hsize;
  logic [13:0] fidx;
  logic [63:0] pea, aha, lsa;
  int          miscompares, total_checks, cyc;
  localparam logic [31:0] SEG = 32'h1234_5678;

  esa_regs DUT (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wide_addr_capability(cap), .frame_index(fidx),
    .list_size_field(lsf), .periodic_entry_addr(pea), .async_head_addr(aha),
    .link_struct_addr(lsa));

  // ----------------------------------------------------------------
  // Clock, bus tie and hang guard
  // ----------------------------------------------------------------
  assign hready = hreadyout;
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask : chk

  // ----------------------------------------------------------------
  // Single AHB-Lite transfer; the master waits for hready each phase.
  // ----------------------------------------------------------------
  task automatic bus(input logic [7:0] a, input logic w, input logic [2:0] sz,
                     input logic [31:0] wd);
    @(posedge clock);
    haddr  <= {24'h00_0000, a};
    htrans <= esa_pkg::HTRANS_NSEQ;
    hwrite <= w;
    hsize  <= sz;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, esa_pkg::HSIZE_WORD, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus(a, 1'b0, esa_pkg::HSIZE_WORD, 32'h0000_0000);
    chk(nm, {32'h0, exp}, {32'h0, rd});
  endtask : rdchk

  // Outputs trail register writes by one edge; three leaves margin.
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask : settle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk(esa_pkg::OFF_SEGMENT, 32'h0000_0000, "seg_rst");
    rdchk(esa_pkg::OFF_PERIODIC, 32'h0000_0000, "per_rst");
    rdchk(esa_pkg::OFF_ASYNC, 32'h0000_0000, "asy_rst");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_narrow();
    wr(esa_pkg::OFF_SEGMENT, 32'hA5A5_0001);
    rdchk(esa_pkg::OFF_SEGMENT, 32'h0000_0000, "seg_narrow");
    wr(esa_pkg::OFF_ASYNC, 32'hFFFF_FFFF);
    rdchk(esa_pkg::OFF_ASYNC, 32'hFFFF_FFE0, "asy_mask");
    wr(esa_pkg::OFF_PERIODIC, 32'hFFFF_FFFF);
    rdchk(esa_pkg::OFF_PERIODIC, 32'hFFFF_F000, "per_mask");
    settle();
    chk("aha_narrow", 64'h0000_0000_FFFF_FFE0, aha);
    $display("t_narrow done");
  endtask : t_narrow

  task automatic t_wide();
    @(posedge clock);
    cap <= 1'b1;
    wr(esa_pkg::OFF_SEGMENT, SEG);
    rdchk(esa_pkg::OFF_SEGMENT, SEG, "seg_wide");
    wr(esa_pkg::OFF_LINK_PTR, 32'h0000_1240);
    settle();
    chk("aha_wide", {SEG, 32'hFFFF_FFE0}, aha);
    chk("lsa_wide", {SEG, 32'h0000_1240}, lsa);
    @(posedge clock);
    cap <= 1'b0;
    settle();
    chk("aha_drop", 64'h0000_0000_FFFF_FFE0, aha);
    chk("lsa_drop", 64'h0000_0000_0000_1240, lsa);
    rdchk(esa_pkg::OFF_SEGMENT, 32'h0000_0000, "seg_hidden");
    $display("t_wide done");
  endtask : t_wide

  task automatic t_index();
    logic [13:0] ix [2];
    int          n;
    logic [31:0] e;
    ix = '{14'h3FF8, 14'h0008};
    @(posedge clock);
    cap <= 1'b1;
    wr(esa_pkg::OFF_PERIODIC, 32'h8765_4321);
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 2; k++) begin
        n = (c == 3) ? 10 : 12 - c;
        e = 32'h8765_4000 | ((32'(ix[k] >> 3) & ((32'h1 << (n - 2)) - 1)) << 2);
        @(posedge clock);
        lsf  <= 2'(c);
        fidx <= ix[k];
        settle();
        chk("pea", {SEG, e}, pea);
      end
    end
    $display("t_index done");
  endtask : t_index

  task automatic t_refuse();
    wr(8'h40, 32'hDEAD_BEEF);
    rdchk(8'h40, 32'h0000_0000, "unmapped");
    bus(esa_pkg::OFF_ASYNC, 1'b1, 3'h0, 32'h0000_0100);
    rdchk(esa_pkg::OFF_ASYNC, 32'hFFFF_FFE0, "asy_byte");
    chk("hresp", 64'h0, {63'h0, hresp});
    $display("t_refuse done");
  endtask : t_refuse

  initial begin
    clock        = 1'b0;
    rstn         = 1'b0;
    hsel         = 1'b1;
    haddr        = 32'h0;
    htrans       = 2'h0;
    hwrite       = 1'b0;
    hsize        = esa_pkg::HSIZE_WORD;
    hwdata       = 32'h0;
    cap          = 1'b0;
    fidx         = 14'h0;
    lsf          = 2'h0;
    miscompares  = 0;
    total_checks = 0;
    cyc          = 0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    t_reset();
    t_narrow();
    t_wide();
    t_index();
    t_refuse();
    close_out();
  end
endmodule : esa_regs_tb_top

// >>> inc/esa_pkg.sv
package esa_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_SEGMENT  = 8'h1C;
  localparam logic [7:0] OFF_PERIODIC = 8'h20;
  localparam logic [7:0] OFF_ASYNC    = 8'h24;
  localparam logic [7:0] OFF_LINK_PTR = 8'h28;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int          PER_LO       = 12;
  localparam int          ASY_LO       = 5;
  localparam logic [31:0] PER_MASK     = 32'hFFFF_F000;
  localparam logic [31:0] ASY_MASK     = 32'hFFFF_FFE0;
  localparam logic [31:0] SEG_RESET    = 32'h0000_0000;
  localparam logic [31:0] PER_RESET    = 32'h0000_0000;
  localparam logic [31:0] ASY_RESET    = 32'h0000_0000;
  localparam logic [31:0] LNK_RESET    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Frame list sizes
  // ----------------------------------------------------------------
  localparam logic [1:0]  LIST_1024    = 2'h0;
  localparam logic [1:0]  LIST_512     = 2'h1;
  localparam logic [1:0]  LIST_256     = 2'h2;
  localparam int          FRIDX_W      = 14;

  // ----------------------------------------------------------------
  // AHB encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
  localparam logic [2:0]  HSIZE_WORD   = 3'h2;

endpackage : esa_pkg

// >>> rtl/esa_addr_gen.sv
`timescale 1ns/1ps
module esa_addr_gen (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Capability strap, stored pointers and frame selection
  input  wire logic        wide_addr_capability,
  input  wire logic [31:0] control_segment,
  input  wire logic [31:0] periodic_list_base_a,
  input  wire logic [31:0] async_list_address,
  input  wire logic [31:0] link_pointer_field,
  input  wire logic [13:0] frame_index,
  input  wire logic [1:0]  list_size_field,
  // Generated addresses
  output logic      [63:0] periodic_entry_addr,
  output logic      [63:0] async_head_addr,
  output logic      [63:0] link_struct_addr
);

  logic [31:0] upper_d;
  logic [31:0] entry_off;
  logic [63:0] per_d;
  logic [63:0] asy_d;
  logic [63:0] lnk_d;

  always_comb begin
    // The segment only counts in 64-bit mode; otherwise the top word is forced low.
    upper_d = wide_addr_capability ? control_segment : 32'h0000_0000;
    // Index bits N..3 pick the entry; each entry is four bytes wide.
    case (list_size_field)
      esa_pkg::LIST_1024: entry_off = {20'h00000, frame_index[12:3], 2'h0};
      esa_pkg::LIST_512:  entry_off = {21'h0, frame_index[11:3], 2'h0};
      esa_pkg::LIST_256:  entry_off = {22'h0, frame_index[10:3], 2'h0};
      default:            entry_off = {22'h0, frame_index[10:3], 2'h0};
    endcase
    per_d = {upper_d, periodic_list_base_a[31:esa_pkg::PER_LO], entry_off[11:0]};
    asy_d = {upper_d, async_list_address[31:esa_pkg::ASY_LO], 5'h00};
    lnk_d = {upper_d, link_pointer_field};
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      periodic_entry_addr <= 64'h0;
      async_head_addr     <= 64'h0;
      link_struct_addr    <= 64'h0;
    end else begin
      periodic_entry_addr <= per_d;
      async_head_addr     <= asy_d;
      link_struct_addr    <= lnk_d;
    end
  end

  a_upper_zero_narrow: assert property (@(posedge clock) disable iff (!rstn)
    !$past(wide_addr_capability) |-> periodic_entry_addr[63:32] == 32'h0 &&
      async_head_addr[63:32] == 32'h0 && link_struct_addr[63:32] == 32'h0)
    else $error("Upper address word not zero in 32-bit mode.");

  a_upper_segment_wide: assert property (@(posedge clock) disable iff (!rstn)
    $past(rstn) && $past(wide_addr_capability) |->
      async_head_addr[63:32] == $past(control_segment))
    else $error("Upper address word does not follow the segment.");

  a_entry_index_1024: assert property (@(posedge clock) disable iff (!rstn)
    $past(rstn) && $past(list_size_field) == 2'h0 |->
      periodic_entry_addr[11:0] == {$past(frame_index[12:3]), 2'h0})
    else $error("Frame list entry offset wrong for 1024 entries.");

  a_entry_index_512: assert property (@(posedge clock) disable iff (!rstn)
    $past(rstn) && $past(list_size_field) == 2'h1 |->
      periodic_entry_addr[11:0] == {1'b0, $past(frame_index[11:3]), 2'h0})
    else $error("Frame list entry offset wrong for 512 entries.");

  a_entry_index_256: assert property (@(posedge clock) disable iff (!rstn)
    $past(rstn) && $past(list_size_field) == 2'h2 |->
      periodic_entry_addr[11:0] == {2'h0, $past(frame_index[10:3]), 2'h0})
    else $error("Frame list entry offset wrong for 256 entries.");

  a_entry_base_kept: assert property (@(posedge clock) disable iff (!rstn)
    $past(rstn) |-> periodic_entry_addr[31:12] == $past(periodic_list_base_a[31:12]))
    else $error("Frame list entry lost the stored base.");

endmodule : esa_addr_gen

// >>> rtl/esa_regs.sv
`timescale 1ns/1ps
// Contract
// - With 64-bit capability clear, segment writes are ignored, it reads zero and is unused.
// - With 64-bit capability set, the segment forms address bits 63..32 above every pointer.
// - The periodic base keeps bits 31..12 only; bits 11..0 read as zero.
// - Frame list entry addresses combine the periodic base with the frame index.
// - The async pointer keeps bits 31..5 only; bits 4..0 read as zero.
// - Frame index bits N..3 select the entry, N being 12, 11 or 10 by list size.
module esa_regs (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Schedule engine side
  input  wire logic        wide_addr_capability,
  input  wire logic [13:0] frame_index,
  input  wire logic [1:0]  list_size_field,
  output logic      [63:0] periodic_entry_addr,
  output logic      [63:0] async_head_addr,
  output logic      [63:0] link_struct_addr
);

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic        wr_pend_q, wr_pend_d;
  logic [7:0]  wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic        access;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0] seg_q, seg_d;
  logic [31:0] per_q, per_d;
  logic [31:0] asy_q, asy_d;
  logic [31:0] lnk_q, lnk_d;

  // The capability strap comes from another block on this clock, so no synchroniser.
  assign access = hsel && hready && htrans == esa_pkg::HTRANS_NSEQ;

  always_comb begin
    wr_pend_d = access && hwrite && hsize == esa_pkg::HSIZE_WORD;
    wr_addr_d = haddr[7:0];
    rdata_d   = 32'h0000_0000;
    if (access && !hwrite) begin
      case (haddr[7:0])
        esa_pkg::OFF_SEGMENT:  rdata_d = wide_addr_capability ? seg_q : 32'h0000_0000;
        esa_pkg::OFF_PERIODIC: rdata_d = per_q & esa_pkg::PER_MASK;
        esa_pkg::OFF_ASYNC:    rdata_d = asy_q & esa_pkg::ASY_MASK;
        esa_pkg::OFF_LINK_PTR: rdata_d = lnk_q;
        default:               rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    seg_d = seg_q;
    per_d = per_q;
    asy_d = asy_q;
    lnk_d = lnk_q;
    if (wr_pend_q) begin
      case (wr_addr_q)
        esa_pkg::OFF_SEGMENT: begin
          // Writes are dropped when the part cannot address above 4 GB.
          if (wide_addr_capability) begin
            seg_d = hwdata;
          end
        end
        // Only the aligned upper bits are stored.
        esa_pkg::OFF_PERIODIC: per_d = hwdata & esa_pkg::PER_MASK;
        // Software must place a queue head here; the block cannot check the type.
        esa_pkg::OFF_ASYNC:    asy_d = hwdata & esa_pkg::ASY_MASK;
        esa_pkg::OFF_LINK_PTR: lnk_d = hwdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q   <= 32'h0000_0000;
      seg_q     <= esa_pkg::SEG_RESET;
      per_q     <= esa_pkg::PER_RESET;
      asy_q     <= esa_pkg::ASY_RESET;
      lnk_q     <= esa_pkg::LNK_RESET;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q   <= rdata_d;
      seg_q     <= seg_d;
      per_q     <= per_d;
      asy_q     <= asy_d;
      lnk_q     <= lnk_d;
    end
  end

  // Zero wait states and an OKAY response keep the slave simple.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata = rdata_q;

  // ----------------------------------------------------------------
  // Address generation
  // ----------------------------------------------------------------
  esa_addr_gen u_addr_gen (
    .clock                (clock),
    .rstn                 (rstn),
    .wide_addr_capability (wide_addr_capability),
    .control_segment      (seg_q),
    .periodic_list_base_a (per_q),
    .async_list_address   (asy_q),
    .link_pointer_field   (lnk_q),
    .frame_index          (frame_index),
    .list_size_field      (list_size_field),
    .periodic_entry_addr  (periodic_entry_addr),
    .async_head_addr      (async_head_addr),
    .link_struct_addr     (link_struct_addr)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Checks on generated addresses skip the edge after reset, whose inputs were not yet live.
  a_seg_write_block: assert property (@(posedge clock) disable iff (!rstn)
    !wide_addr_capability |=> seg_q == $past(seg_q))
    else $error("Segment changed without 64-bit capability.");

  a_seg_read_zero: assert property (@(posedge clock) disable iff (!rstn)
    access && !hwrite && haddr[7:0] == esa_pkg::OFF_SEGMENT && !wide_addr_capability
      |=> hrdata == 32'h0)
    else $error("Segment read not zero without 64-bit capability.");

  a_per_low_zero: assert property (@(posedge clock) disable iff (!rstn)
    per_q[11:0] == 12'h000)
    else $error("Periodic base low bits not zero.");

  a_asy_low_zero: assert property (@(posedge clock) disable iff (!rstn)
    access && !hwrite && haddr[7:0] == esa_pkg::OFF_ASYNC |=> hrdata[4:0] == 5'h00)
    else $error("Async pointer low bits not zero on read.");

  a_per_write_lands: assert property (@(posedge clock) disable iff (!rstn)
    wr_pend_q && wr_addr_q == esa_pkg::OFF_PERIODIC |=>
      per_q[31:12] == $past(hwdata[31:12]))
    else $error("Periodic base write not stored.");

  a_seg_write_lands: assert property (@(posedge clock) disable iff (!rstn)
    wr_pend_q && wr_addr_q == esa_pkg::OFF_SEGMENT && wide_addr_capability |=>
      seg_q == $past(hwdata))
    else $error("Segment write not stored with 64-bit capability.");

  a_asy_write_lands: assert property (@(posedge clock) disable iff (!rstn)
    wr_pend_q && wr_addr_q == esa_pkg::OFF_ASYNC |=>
      asy_q == {$past(hwdata[31:5]), 5'h00})
    else $error("Async pointer write not stored.");

  a_lnk_write_lands: assert property (@(posedge clock) disable iff (!rstn)
    wr_pend_q && wr_addr_q == esa_pkg::OFF_LINK_PTR |=>
      lnk_q == $past(hwdata))
    else $error("Link pointer write not stored.");

  a_seg_read_wide: assert property (@(posedge clock) disable iff (!rstn)
    access && !hwrite && haddr[7:0] == esa_pkg::OFF_SEGMENT && wide_addr_capability
      |=> hrdata == $past(seg_q))
    else $error("Segment read does not return the stored value.");

  a_per_read_value: assert property (@(posedge clock) disable iff (!rstn)
    access && !hwrite && haddr[7:0] == esa_pkg::OFF_PERIODIC
      |=> hrdata == {$past(per_q[31:12]), 12'h000})
    else $error("Periodic base read wrong or low bits not zero.");

  a_asy_read_value: assert property (@(posedge clock) disable iff (!rstn)
    access && !hwrite && haddr[7:0] == esa_pkg::OFF_ASYNC
      |=> hrdata[31:5] == $past(asy_q[31:5]))
    else $error("Async pointer read does not return the stored value.");

  a_narrow_unused: assert property (@(posedge clock) disable iff (!rstn)
    $past(rstn) && !$past(wide_addr_capability) |->
      async_head_addr[63:32] == 32'h0 && periodic_entry_addr[63:32] == 32'h0)
    else $error("Segment used for addresses without 64-bit capability.");

  a_wide_link_upper: assert property (@(posedge clock) disable iff (!rstn)
    $past(rstn) && $past(wide_addr_capability) |->
      link_struct_addr[63:32] == $past(seg_q) && periodic_entry_addr[63:32] == $past(seg_q))
    else $error("Segment not placed above the link or periodic pointer.");

  a_byte_write_drop: assert property (@(posedge clock) disable iff (!rstn)
    access && hwrite && hsize != esa_pkg::HSIZE_WORD |=>
      !wr_pend_q)
    else $error("Non-word write was accepted.");

  a_unmapped_zero: assert property (@(posedge clock) disable iff (!rstn)
    access && !hwrite && haddr[7:0] != esa_pkg::OFF_SEGMENT &&
      haddr[7:0] != esa_pkg::OFF_PERIODIC && haddr[7:0] != esa_pkg::OFF_ASYNC &&
      haddr[7:0] != esa_pkg::OFF_LINK_PTR |=> hrdata == 32'h0)
    else $error("Unmapped read did not return zero.");

  // Read data stands for one data phase only, so stale words never leak into later cycles.
  a_idle_read_zero: assert property (@(posedge clock) disable iff (!rstn)
    !(access && !hwrite) |=>
      hrdata == 32'h0000_0000)
    else $error("Read data not zero outside a read data phase.");

  a_ready_okay: assert property (@(posedge clock) disable iff (!rstn)
    $past(rstn) |->
      hreadyout && !hresp)
    else $error("Slave not ready or not OKAY after reset.");

endmodule : esa_regs
